// File: core/fopr_pkg.sv
// package: constants and types for the flash option and protection registers
package fopr_pkg;
    // ****************************************
    // bus map and field layout
    // ****************************************
    localparam logic [3:0] OFS_OPTION = 4'h0;
    localparam logic [3:0] OFS_CONFIG = 4'h4;
    localparam logic [3:0] OFS_PROTECT = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;
    localparam int OPT_UNLOCK_BIT = 7;
    localparam int OPT_NOREDIR_BIT = 6;
    localparam logic [7:0] OPT_RSVD_MASK = 8'h3c;
    localparam logic [7:0] CFG_RW_MASK = 8'he0;
    localparam int CFG_KEYWR_BIT = 5;
    localparam int PROT_OFF_BIT = 0;
    localparam int STAT_VIOL_BIT = 0;
    localparam int STAT_SECURE_BIT = 1;
    localparam logic [1:0] LOCK_OPEN = 2'b10;
    // ****************************************
    // unlock word and protection boundary
    // ****************************************
    localparam logic [15:0] KEY_BASE = 16'hffb0;
    localparam logic [3:0] KEY_FULL = 4'h8;
    localparam logic [8:0] LIMIT_FILL = 9'h1ff;
    localparam logic [1:0] WAIT_IDLE = 2'b01;
    typedef enum logic [2:0] {
        KS_IDLE = 3'b001,
        KS_COLLECT = 3'b010,
        KS_FAIL = 3'b100
    } fopr_key_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic from_debug;
    } fopr_fwr_t;
    typedef struct packed {
        logic [7:0] option;
        logic [7:0] config_r;
        logic [7:0] protect;
        logic viol;
        fopr_key_t key_st;
        logic [3:0] key_idx;
        logic [63:0] key;
        logic cmd_go;
        logic [15:0] cmd_addr;
        logic [7:0] cmd_data;
        logic wait_r;
        logic [31:0] rdata;
        logic secure;
        logic redir_en;
    } fopr_state_t;
endpackage

// File: core/fopr_top.sv
// module: flash option, security, unlock-word and block protection registers
`timescale 1ns/10ps

// Contract
// - option register reloads from the stored option byte at every reset
// - option bits 5:2 read zero; bus writes to the option register never change it
// - unlock enable bit 7 clear: unlock word can never open security
// - matching eight-byte word written in ascending order opens security
// - unlock word bytes written from background debug are ignored
// - option bit 6 set disables vector redirection, clear enables it
// - lock field 1:0 means unsecured; opens on word match or blank check
// - config bits 7:5 read and write freely
// - config bits 4:0 read zero and ignore writes
// - key window writes start commands, or load word bytes if enabled
// - protection register reloads from stored byte at reset, always readable
// - protection off bit clear: only a smaller select value is accepted
// - protection off bit set: writes leave protection unchanged
// - select field bits 7:1 sets last unprotected address; above is locked
// - erase or program aimed at a protected location is refused
// - protection off bit set: nothing is protected
// - clearing word write enable after eight bytes runs the comparison
// - protection register writable only by background debug accesses
// - refused command sets violation flag; writing one clears it
module fopr_top (
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [3:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    input wire logic AVS_DEBUG_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire logic [7:0] NV_OPTION_IN,
    input wire logic [7:0] NV_PROTECT_IN,
    input wire logic [63:0] NV_KEY_IN,
    input wire logic FWR_VALID_IN,
    input wire fopr_pkg::fopr_fwr_t FWR_IN,
    input wire logic BLANK_OK_IN,
    output logic CMD_START_OUT,
    output logic [15:0] CMD_ADDR_OUT,
    output logic [7:0] CMD_DATA_OUT,
    output logic VIOLATION_OUT,
    output logic SECURE_OUT,
    output logic REDIRECT_EN_OUT
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic is_protected(input logic [15:0] a,
                                          input logic [7:0] p);
        logic [15:0] limit;
        limit = {p[7:1], fopr_pkg::LIMIT_FILL};
        is_protected = !p[fopr_pkg::PROT_OFF_BIT] && (a > limit);
    endfunction

    function automatic logic in_key_window(input logic [15:0] a);
        in_key_window = (a[15:3] == fopr_pkg::KEY_BASE[15:3]);
    endfunction

    function automatic fopr_pkg::fopr_state_t reset_state(
        input logic [7:0] nv_opt, input logic [7:0] nv_prot);
        fopr_pkg::fopr_state_t r;
        r = '0;
        r.option = nv_opt & ~fopr_pkg::OPT_RSVD_MASK;
        r.protect = nv_prot;
        r.key_st = fopr_pkg::KS_IDLE;
        r.wait_r = 1'b1;
        r.secure = (r.option[1:0] != fopr_pkg::LOCK_OPEN);
        r.redir_en = !r.option[fopr_pkg::OPT_NOREDIR_BIT];
        reset_state = r;
    endfunction

    // ****************************************
    // state
    // ****************************************
    fopr_pkg::fopr_state_t s_reg;
    fopr_pkg::fopr_state_t s_next;
    logic wr_now;
    logic fwr_key;
    logic [7:0] wbyte;
    logic [7:0] rbyte;

    assign wr_now = AVS_WRITE_IN && !s_reg.wait_r && AVS_BYTEENABLE_IN[0];
    assign wbyte = AVS_WRITEDATA_IN[7:0];
    assign fwr_key = s_reg.config_r[fopr_pkg::CFG_KEYWR_BIT] &&
                     in_key_window(FWR_IN.addr);

    always_comb begin
        s_next = s_reg;
        s_next.cmd_go = 1'b0;
        s_next.wait_r = 1'b1;
        // bus read mux, one wait cycle per access
        case (AVS_ADDRESS_IN)
            fopr_pkg::OFS_OPTION: rbyte = s_reg.option;
            fopr_pkg::OFS_CONFIG: rbyte = s_reg.config_r;
            fopr_pkg::OFS_PROTECT: rbyte = s_reg.protect;
            fopr_pkg::OFS_STATUS: begin
                rbyte = '0;
                rbyte[fopr_pkg::STAT_VIOL_BIT] = s_reg.viol;
                rbyte[fopr_pkg::STAT_SECURE_BIT] = s_reg.secure;
            end
            default: rbyte = '0;
        endcase
        if ((AVS_READ_IN || AVS_WRITE_IN) && s_reg.wait_r) begin
            s_next.wait_r = 1'b0;
            s_next.rdata = {24'h0, rbyte};
        end
        // option register takes no bus write: no branch for it
        if (wr_now && AVS_ADDRESS_IN == fopr_pkg::OFS_CONFIG) begin
            s_next.config_r = wbyte & fopr_pkg::CFG_RW_MASK;
            if (wbyte[fopr_pkg::CFG_KEYWR_BIT] &&
                !s_reg.config_r[fopr_pkg::CFG_KEYWR_BIT]) begin
                s_next.key_st = fopr_pkg::KS_COLLECT;
                s_next.key_idx = '0;
            end
            if (!wbyte[fopr_pkg::CFG_KEYWR_BIT] &&
                s_reg.config_r[fopr_pkg::CFG_KEYWR_BIT]) begin
                s_next.key_st = fopr_pkg::KS_IDLE;
                // compare on release of the write enable
                if (s_reg.option[fopr_pkg::OPT_UNLOCK_BIT] &&
                    s_reg.key_st == fopr_pkg::KS_COLLECT &&
                    s_reg.key_idx == fopr_pkg::KEY_FULL &&
                    s_reg.key == NV_KEY_IN) begin
                    s_next.option[1:0] = fopr_pkg::LOCK_OPEN;
                end
            end
        end
        // only debug accesses may tighten protection
        if (wr_now && AVS_DEBUG_IN &&
            AVS_ADDRESS_IN == fopr_pkg::OFS_PROTECT) begin
            if (!s_reg.protect[fopr_pkg::PROT_OFF_BIT] &&
                wbyte[7:1] < s_reg.protect[7:1]) begin
                s_next.protect[7:1] = wbyte[7:1];
            end
        end
        if (wr_now && AVS_ADDRESS_IN == fopr_pkg::OFS_STATUS &&
            wbyte[fopr_pkg::STAT_VIOL_BIT]) begin
            s_next.viol = 1'b0;
        end
        // flash array writes: unlock word byte or command launch
        if (FWR_VALID_IN) begin
            if (fwr_key) begin
                if (!FWR_IN.from_debug &&
                    s_reg.key_st == fopr_pkg::KS_COLLECT) begin
                    if (s_reg.key_idx != fopr_pkg::KEY_FULL &&
                        FWR_IN.addr[2:0] == s_reg.key_idx[2:0]) begin
                        s_next.key[{s_reg.key_idx[2:0], 3'h0} +: 8] =
                            FWR_IN.data;
                        s_next.key_idx = s_reg.key_idx + 4'h1;
                    end else begin
                        s_next.key_st = fopr_pkg::KS_FAIL;
                    end
                end
            end else if (is_protected(FWR_IN.addr, s_reg.protect)) begin
                s_next.viol = 1'b1;
            end else begin
                s_next.cmd_go = 1'b1;
                s_next.cmd_addr = FWR_IN.addr;
                s_next.cmd_data = FWR_IN.data;
            end
        end
        if (BLANK_OK_IN) begin
            s_next.option[1:0] = fopr_pkg::LOCK_OPEN;
        end
        s_next.secure = (s_next.option[1:0] != fopr_pkg::LOCK_OPEN);
        s_next.redir_en = !s_next.option[fopr_pkg::OPT_NOREDIR_BIT];
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            s_reg <= reset_state(NV_OPTION_IN, NV_PROTECT_IN);
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign AVS_READDATA_OUT = s_reg.rdata;
    assign AVS_WAITREQUEST_OUT = s_reg.wait_r;
    assign CMD_START_OUT = s_reg.cmd_go;
    assign CMD_ADDR_OUT = s_reg.cmd_addr;
    assign CMD_DATA_OUT = s_reg.cmd_data;
    assign VIOLATION_OUT = s_reg.viol;
    assign SECURE_OUT = s_reg.secure;
    assign REDIRECT_EN_OUT = s_reg.redir_en;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    opt_rsvd_zero_a: assert property (
        (s_reg.option & fopr_pkg::OPT_RSVD_MASK) == 8'h00)
        else $error("option reserved bits not zero");

    opt_upper_hold_a: assert property (
        ##1 s_reg.option[7:2] == $past(s_reg.option[7:2]))
        else $error("option upper bits changed after reset");

    no_unlock_dis_a: assert property (
        !s_reg.option[fopr_pkg::OPT_UNLOCK_BIT] && s_reg.secure &&
        !BLANK_OK_IN |=> s_reg.secure)
        else $error("security opened with unlock disabled");

    debug_key_a: assert property (
        FWR_VALID_IN && FWR_IN.from_debug |=> $stable(s_reg.key_idx))
        else $error("debug write took part in unlock word");

    redir_map_a: assert property (
        s_reg.redir_en == !s_reg.option[fopr_pkg::OPT_NOREDIR_BIT])
        else $error("redirect enable does not follow option bit");

    cfg_low_zero_a: assert property (
        (s_reg.config_r & ~fopr_pkg::CFG_RW_MASK) == 8'h00)
        else $error("config low bits not zero");

    prot_tighten_a: assert property (
        ##1 s_reg.protect[7:1] <= $past(s_reg.protect[7:1]))
        else $error("protection was loosened");

    prot_off_hold_a: assert property (
        s_reg.protect[fopr_pkg::PROT_OFF_BIT] |=> $stable(s_reg.protect))
        else $error("protection changed while disabled");

    prot_app_hold_a: assert property (
        wr_now && !AVS_DEBUG_IN |=> $stable(s_reg.protect))
        else $error("application write altered protection");

    viol_refuse_a: assert property (
        FWR_VALID_IN && !fwr_key &&
        is_protected(FWR_IN.addr, s_reg.protect)
        |=> s_reg.viol && !s_reg.cmd_go)
        else $error("protected command not refused");

    cmd_launch_a: assert property (
        FWR_VALID_IN && !fwr_key &&
        !is_protected(FWR_IN.addr, s_reg.protect)
        |=> s_reg.cmd_go && s_reg.cmd_addr == $past(FWR_IN.addr))
        else $error("command not launched");

    bus_answer_a: assert property (
        (AVS_READ_IN || AVS_WRITE_IN) && s_reg.wait_r
        |=> !s_reg.wait_r ##1 s_reg.wait_r)
        else $error("bus answer timing wrong");

    key_no_cmd_a: assert property (
        FWR_VALID_IN && fwr_key |=> !s_reg.cmd_go)
        else $error("unlock word byte launched a command");

    secure_map_a: assert property (
        s_reg.secure == (s_reg.option[1:0] != fopr_pkg::LOCK_OPEN))
        else $error("secure flag does not follow lock field");

    blank_open_a: assert property (
        BLANK_OK_IN |=> !s_reg.secure)
        else $error("blank check did not open security");

    unlock_only_a: assert property (
        s_reg.secure && !BLANK_OK_IN &&
        !(wr_now && AVS_ADDRESS_IN == fopr_pkg::OFS_CONFIG)
        |=> s_reg.secure)
        else $error("security opened outside word compare or blank check");

    opt_write_hold_a: assert property (
        wr_now && AVS_ADDRESS_IN == fopr_pkg::OFS_OPTION && !BLANK_OK_IN
        |=> $stable(s_reg.option))
        else $error("bus write changed option register");

    cfg_write_a: assert property (
        wr_now && AVS_ADDRESS_IN == fopr_pkg::OFS_CONFIG
        |=> s_reg.config_r == ($past(wbyte) & fopr_pkg::CFG_RW_MASK))
        else $error("config write not taken");

    viol_hold_a: assert property (
        s_reg.viol && !(wr_now && wbyte[fopr_pkg::STAT_VIOL_BIT] &&
        AVS_ADDRESS_IN == fopr_pkg::OFS_STATUS) |=> s_reg.viol)
        else $error("violation flag dropped without a clear");

    viol_clear_a: assert property (
        wr_now && wbyte[fopr_pkg::STAT_VIOL_BIT] &&
        AVS_ADDRESS_IN == fopr_pkg::OFS_STATUS && !FWR_VALID_IN
        |=> !s_reg.viol)
        else $error("violation flag not cleared by writing one");

    prot_off_open_a: assert property (
        FWR_VALID_IN && !fwr_key && s_reg.protect[fopr_pkg::PROT_OFF_BIT]
        |=> s_reg.cmd_go)
        else $error("command refused while protection is off");

    key_order_a: assert property (
        FWR_VALID_IN && fwr_key && !FWR_IN.from_debug &&
        s_reg.key_st == fopr_pkg::KS_COLLECT &&
        FWR_IN.addr[2:0] != s_reg.key_idx[2:0]
        |=> s_reg.key_st == fopr_pkg::KS_FAIL)
        else $error("out of order word byte accepted");

    unlock_cov_c: cover property (
        s_reg.secure ##1 !s_reg.secure && !$past(BLANK_OK_IN));
    viol_cov_c: cover property (!s_reg.viol ##1 s_reg.viol);
    tighten_cov_c: cover property (
        ##1 s_reg.protect[7:1] < $past(s_reg.protect[7:1]));
    launch_cov_c: cover property (s_reg.cmd_go);
    keyfail_cov_c: cover property (s_reg.key_st == fopr_pkg::KS_FAIL);
endmodule

// File: bench/fopr_top_bench.sv
// testbench: option, unlock word and block protection scenarios
`timescale 1ns/10ps
module fopr_top_bench;
    logic clk, rst_n, rd_en, wr_en, dbg, fv, blank;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, r;
    logic wreq, start, viol, sec, redir;
    logic [7:0] nv_opt, nv_prot, cdata;
    logic [63:0] nv_key;
    logic [15:0] caddr;
    fopr_pkg::fopr_fwr_t fwr;
    int bad_count, comparisons;

    fopr_top i_fopr_top (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
        .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd_en), .AVS_WRITE_IN(wr_en),
        .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'h1),
        .AVS_DEBUG_IN(dbg), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(wreq), .NV_OPTION_IN(nv_opt),
        .NV_PROTECT_IN(nv_prot), .NV_KEY_IN(nv_key), .FWR_VALID_IN(fv),
        .FWR_IN(fwr), .BLANK_OK_IN(blank), .CMD_START_OUT(start),
        .CMD_ADDR_OUT(caddr), .CMD_DATA_OUT(cdata), .VIOLATION_OUT(viol),
        .SECURE_OUT(sec), .REDIRECT_EN_OUT(redir));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d, input logic b);
        int n;
        addr <= a;
        wdata <= {24'h0, d};
        dbg <= b;
        wr_en <= w;
        rd_en <= !w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        r = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        dbg <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            conclude();
        end
        @(posedge clk);
    endtask

    task automatic rdreg(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 1'b0);
        chk("register", r, {24'h0, e});
    endtask

    task automatic flash(input logic [15:0] a, input logic [7:0] d,
                         input logic b);
        fv <= 1'b1;
        fwr <= '{addr: a, data: d, from_debug: b};
        @(posedge clk);
        fv <= 1'b0;
        @(posedge clk);
    endtask

    task automatic reboot(input logic [7:0] o, input logic [7:0] p);
        rst_n <= 1'b0;
        nv_opt <= o;
        nv_prot <= p;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask

    task automatic key_seq(input logic b);
        bus(1'b1, fopr_pkg::OFS_CONFIG, 8'h20, 1'b0);
        for (int i = 0; i < 8; i++) begin
            flash(16'hffb0 + 16'(i), nv_key[8*i +: 8], b);
            chk("key start", {31'h0, start}, 32'h0);
        end
        bus(1'b1, fopr_pkg::OFS_CONFIG, 8'h00, 1'b0);
        @(posedge clk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_option;
        reboot(8'hc3, 8'hff);
        rdreg(fopr_pkg::OFS_OPTION, 8'hc3);
        chk("redirect", {31'h0, redir}, 32'h0);
        chk("secure", {31'h0, sec}, 32'h1);
        bus(1'b1, fopr_pkg::OFS_OPTION, 8'h00, 1'b1);
        rdreg(fopr_pkg::OFS_OPTION, 8'hc3);
        reboot(8'h3e, 8'hff);
        rdreg(fopr_pkg::OFS_OPTION, 8'h02);
        chk("redirect", {31'h0, redir}, 32'h1);
        chk("secure", {31'h0, sec}, 32'h0);
        reboot(8'h80, 8'hff);
        chk("secure", {31'h0, sec}, 32'h1);
        reboot(8'h01, 8'hff);
        chk("secure", {31'h0, sec}, 32'h1);
        bus(1'b1, fopr_pkg::OFS_CONFIG, 8'hff, 1'b0);
        rdreg(fopr_pkg::OFS_CONFIG, 8'he0);
        bus(1'b1, fopr_pkg::OFS_CONFIG, 8'h1f, 1'b0);
        rdreg(fopr_pkg::OFS_CONFIG, 8'h00);
        rdreg(4'h2, 8'h00);
        $display("option and config test done");
    endtask

    task automatic t_key;
        reboot(8'hc3, 8'hff);
        key_seq(1'b0);
        chk("secure", {31'h0, sec}, 32'h0);
        rdreg(fopr_pkg::OFS_STATUS, 8'h00);
        reboot(8'hc3, 8'hff);
        key_seq(1'b1);
        chk("secure", {31'h0, sec}, 32'h1);
        reboot(8'hc3, 8'hff);
        bus(1'b1, fopr_pkg::OFS_CONFIG, 8'h20, 1'b0);
        for (int i = 7; i >= 0; i--) begin
            flash(16'hffb0 + 16'(i), nv_key[8*i +: 8], 1'b0);
        end
        bus(1'b1, fopr_pkg::OFS_CONFIG, 8'h00, 1'b0);
        @(posedge clk);
        chk("secure", {31'h0, sec}, 32'h1);
        reboot(8'h43, 8'hff);
        key_seq(1'b0);
        chk("secure", {31'h0, sec}, 32'h1);
        blank <= 1'b1;
        @(posedge clk);
        blank <= 1'b0;
        repeat (2) @(posedge clk);
        chk("secure", {31'h0, sec}, 32'h0);
        $display("unlock word test done");
    endtask

    task automatic t_protect;
        reboot(8'hc3, 8'hf0);
        rdreg(fopr_pkg::OFS_PROTECT, 8'hf0);
        flash(16'hf200, 8'h5a, 1'b0);
        chk("start", {31'h0, start}, 32'h0);
        chk("violation", {31'h0, viol}, 32'h1);
        flash(16'hf1ff, 8'ha5, 1'b0);
        chk("start", {31'h0, start}, 32'h1);
        chk("cmd addr", {16'h0, caddr}, 32'hf1ff);
        chk("cmd data", {24'h0, cdata}, 32'ha5);
        bus(1'b1, fopr_pkg::OFS_STATUS, 8'h01, 1'b0);
        chk("violation", {31'h0, viol}, 32'h0);
        bus(1'b1, fopr_pkg::OFS_PROTECT, 8'h80, 1'b0);
        rdreg(fopr_pkg::OFS_PROTECT, 8'hf0);
        bus(1'b1, fopr_pkg::OFS_PROTECT, 8'h80, 1'b1);
        rdreg(fopr_pkg::OFS_PROTECT, 8'h80);
        bus(1'b1, fopr_pkg::OFS_PROTECT, 8'ha0, 1'b1);
        rdreg(fopr_pkg::OFS_PROTECT, 8'h80);
        flash(16'h8200, 8'h11, 1'b0);
        chk("violation", {31'h0, viol}, 32'h1);
        flash(16'h81ff, 8'h22, 1'b0);
        chk("start", {31'h0, start}, 32'h1);
        reboot(8'hc3, 8'h01);
        flash(16'hfff0, 8'h33, 1'b0);
        chk("start", {31'h0, start}, 32'h1);
        chk("violation", {31'h0, viol}, 32'h0);
        flash(16'hffb0, 8'h44, 1'b0);
        chk("start", {31'h0, start}, 32'h1);
        bus(1'b1, fopr_pkg::OFS_PROTECT, 8'h00, 1'b1);
        rdreg(fopr_pkg::OFS_PROTECT, 8'h01);
        $display("protection test done");
    endtask

    initial begin
        rst_n = 1'b0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        dbg = 1'b0;
        fv = 1'b0;
        blank = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        nv_opt = 8'hc3;
        nv_prot = 8'hff;
        nv_key = 64'h8877665544332211;
        fwr = '{addr: 16'h0, data: 8'h0, from_debug: 1'b0};
        bad_count = 0;
        comparisons = 0;
        t_option();
        t_key();
        t_protect();
        conclude();
    end
endmodule
